// file: rwps_device.sv
// bridge device end: wake decision and phy power gating
// Functional notes
// - strap low: host resume always wakes device
// - no self wake without flag and feature; strap high, suspend ends in remote wake on ready_src without them
// - frame select wakes on wakeup frame
// - magic select wakes on magic packet
// - link select wakes on either link change
// - external pin low pulse wakes regardless
// - ready mode: magic, secondary link, pin wake
// - full power-down stops all, at least 500ns
// - control bit 11 stops only bandgap
// - host waits 600ms after power-up
// - reset held longer than stabilisation time
// - 500ns phy reset after stabilisation
// - software phy reset at least 500ns
// - phy mode secondary link-up wakes
// - ready mode wake raises power event
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module rwps_device
  import rwps_pkg::*;
#(
  parameter int T1_CYCLES = T1_CYC,
  parameter int RWAKE_CYCLES = RWAKE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host link
  rwps_if.dev link,
  // configuration
  input wire logic default_mode_strap,
  input wire logic remote_wake_enable_flag,
  input wire logic wake_on_frame_select,
  input wire logic wake_on_magic_select,
  input wire logic wake_on_link_change_select,
  input wire logic phy_mode,
  input wire logic [15:0] phy_basic_control_reg,
  // wake sources
  input wire logic wake_frame_rx,
  input wire logic magic_packet_rx,
  input wire logic link_change_primary,
  input wire logic link_change_secondary,
  input wire logic secondary_link_up,
  input wire logic external_wake_pin_n,
  // phy power and status
  output logic osc_en,
  output logic pll_en,
  output logic bandgap_en,
  output logic phy_in_reset,
  output logic suspended,
  output logic ready_mode
);
  if (T1_CYCLES < 1 || T1_CYCLES > 65535) begin : g_chk_t1
    $error("T1_CYCLES out of range");
  end
  if (RWAKE_CYCLES < 1 || RWAKE_CYCLES > 65535) begin : g_chk_rw
    $error("RWAKE_CYCLES out of range");
  end

  // pin synchronisers: bit 0 strap, bit 1 wake pin
  logic [1:0] pin_in;
  wire [1:0] pin_lvl_q;
  assign pin_in = {external_wake_pin_n, default_mode_strap};
  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic s1_q, s2_q, s3_q, lvl_q;
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
        s3_q <= 1'b1;
        lvl_q <= 1'b1;
      end else begin
        s1_q <= pin_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          lvl_q <= s2_q;
        end
      end
    end
    assign pin_lvl_q[i] = lvl_q;
  end

  // strap caught once the synchroniser has settled
  // one cycle past the sync depth, so the filtered level is no longer the reset value
  logic [2:0] boot_q;
  logic caught_q;
  logic strap_q;
  wire boot_done = (boot_q == 3'(BOOT_CYC + 1));
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boot_q <= 3'h0;
      caught_q <= 1'b0;
      strap_q <= 1'b0;
    end else if (!boot_done) begin
      boot_q <= boot_q + 3'h1;
    end else if (!caught_q) begin
      caught_q <= 1'b1;
      strap_q <= pin_lvl_q[0];
    end
  end

  // falling edge of the filtered wake pin
  logic ext_prev_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_prev_q <= 1'b1;
    end else begin
      ext_prev_q <= pin_lvl_q[1];
    end
  end
  wire ext_pulse = ext_prev_q & ~pin_lvl_q[1];

  // wake decision
  wire dev_armed = ~strap_q & remote_wake_enable_flag & link.set_feature;
  wire no_sel = ~wake_on_frame_select & ~wake_on_magic_select
    & ~wake_on_link_change_select;
  wire sel_frame = wake_on_frame_select & wake_frame_rx;
  wire sel_magic = wake_on_magic_select & magic_packet_rx;
  wire sel_link = wake_on_link_change_select
    & (link_change_primary | link_change_secondary);
  wire dev_wake = dev_armed & (sel_frame | sel_magic | sel_link | ext_pulse);
  wire ready_src = magic_packet_rx | link_change_secondary | ext_pulse
    | (phy_mode & secondary_link_up);
  wire ready_wake = strap_q & ~link.set_feature & no_sel & ready_src;
  wire host_wake = ~strap_q & link.resume_req;

  // wake state machine
  rwps_dev_st_t st_q, st_d;
  logic [15:0] rw_cnt_q, rw_cnt_d;
  wire rw_done = (rw_cnt_q == 16'(RWAKE_CYCLES - 1));
  always_comb begin
    st_d = st_q;
    rw_cnt_d = rw_cnt_q;
    case (st_q)
      DS_NORMAL: begin
        if (boot_done && !caught_q && pin_lvl_q[0]) begin
          st_d = DS_READY;
        end else if (link.suspend_req) begin
          st_d = DS_SUSP;
        end
      end
      DS_SUSP: begin
        if (host_wake) begin
          st_d = DS_NORMAL;
        end else if (dev_wake || ready_wake) begin
          st_d = DS_RWAKE;
          rw_cnt_d = 16'h0;
        end
      end
      DS_RWAKE: begin
        rw_cnt_d = rw_cnt_q + 16'h1;
        if (rw_done) begin
          st_d = DS_NORMAL;
        end
      end
      DS_READY: begin
        if (ready_wake) begin
          st_d = DS_NORMAL;
        end
      end
      default: st_d = DS_NORMAL;
    endcase
  end

  wire pe_set = (st_q == DS_READY) & ready_wake;
  logic pe_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= DS_NORMAL;
      rw_cnt_q <= 16'h0;
      pe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rw_cnt_q <= rw_cnt_d;
      if (pe_set) begin
        pe_q <= 1'b1;
      end
    end
  end

  // full power-down held at least the minimum time
  logic pd_q;
  logic [15:0] pd_cnt_q;
  wire pd_min_met = (pd_cnt_q >= 16'(T1_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pd_q <= 1'b0;
      pd_cnt_q <= 16'h0;
    end else if (!pd_q) begin
      pd_cnt_q <= 16'h0;
      pd_q <= link.phy_full_power_down;
    end else if (!pd_min_met) begin
      pd_cnt_q <= pd_cnt_q + 16'h1;
    end else if (!link.phy_full_power_down) begin
      pd_q <= 1'b0;
    end
  end

  wire phy_ctrl_pd = phy_basic_control_reg[PHY_CTRL_PD_BIT];

  // registered outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_en <= 1'b0;
      pll_en <= 1'b0;
      bandgap_en <= 1'b0;
      phy_in_reset <= 1'b1;
      suspended <= 1'b0;
      ready_mode <= 1'b0;
      link.power_event_output <= 1'b0;
      link.remote_wake <= 1'b0;
    end else begin
      osc_en <= ~pd_q;
      pll_en <= ~pd_q;
      bandgap_en <= ~pd_q & ~phy_ctrl_pd;
      phy_in_reset <= ~link.phy_reset_release_n | pd_q;
      suspended <= (st_d == DS_SUSP) | (st_d == DS_READY);
      ready_mode <= (st_d == DS_READY);
      link.power_event_output <= pe_q | pe_set;
      link.remote_wake <= (st_d == DS_RWAKE);
    end
  end
endmodule

// file: rwps_host.sv
// host controller end: register port, suspend control and phy sequencing
`timescale 1ns/1ns
module rwps_host
  import rwps_pkg::*;
#(
  parameter int T2_CYCLES = T2_CYC,
  parameter int T3_CYCLES = T3_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // device link
  rwps_if.host link
);
  if (T2_CYCLES < 1 || T3_CYCLES < 1) begin : g_chk
    $error("timing counts must be at least one");
  end

  // address decode
  wire sel_ctrl = (reg_addr == OFS_CTRL);
  wire sel_stat = (reg_addr == OFS_STATUS);
  wire sel_istat = (reg_addr == OFS_IRQ_STAT);
  wire sel_imask = (reg_addr == OFS_IRQ_MASK);
  wire wr_ctrl = reg_wr & sel_ctrl;
  wire cmd_susp = wr_ctrl & reg_wdata[CTRL_SUSPEND];
  wire cmd_res = wr_ctrl & reg_wdata[CTRL_RESUME];
  wire cmd_srst = wr_ctrl & reg_wdata[CTRL_SW_RESET];

  logic [1:0] ctrl_q;
  logic [IRQ_W-1:0] mask_q, stat_q, stat_d, ev;
  logic susp_q, rw_prev_q, pe_prev_q;
  rwps_host_st_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;

  // phy power-up, stabilisation and reset sequence
  wire t2_done = (cnt_q == 32'(T2_CYCLES - 1));
  wire t3_done = (cnt_q == 32'(T3_CYCLES - 1));
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 32'h1;
    case (st_q)
      HS_PD: begin
        cnt_d = 32'h0;
        if (!ctrl_q[CTRL_PHY_PD]) begin
          st_d = HS_STAB;
        end
      end
      HS_STAB: begin
        if (ctrl_q[CTRL_PHY_PD]) begin
          st_d = HS_PD;
        end else if (t2_done) begin
          st_d = HS_RST;
          cnt_d = 32'h0;
        end
      end
      HS_RST: begin
        if (ctrl_q[CTRL_PHY_PD]) begin
          st_d = HS_PD;
        end else if (t3_done) begin
          st_d = HS_RDY;
        end
      end
      HS_RDY: begin
        cnt_d = 32'h0;
        if (ctrl_q[CTRL_PHY_PD]) begin
          st_d = HS_PD;
        end else if (cmd_srst) begin
          st_d = HS_RST;
        end
      end
      default: st_d = HS_PD;
    endcase
  end

  // interrupt events, set wins over clear
  assign ev[IRQ_REMOTE_WAKE] = link.remote_wake & ~rw_prev_q;
  assign ev[IRQ_POWER_EVENT] = link.power_event_output & ~pe_prev_q;
  assign ev[IRQ_PHY_READY] = (st_d == HS_RDY) & (st_q != HS_RDY);
  wire [IRQ_W-1:0] clr = (reg_wr & sel_istat) ? reg_wdata[IRQ_W-1:0] : '0;
  assign stat_d = (stat_q & ~clr) | ev;

  wire [31:0] status_word = {26'h0, susp_q, link.power_event_output,
    (st_q == HS_RDY), st_q[2:0]};
  wire [31:0] rd_mux = sel_ctrl ? {30'h0, ctrl_q} :
    sel_stat ? status_word :
    sel_istat ? {29'h0, stat_q} :
    sel_imask ? {29'h0, mask_q} : 32'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= IRQ_MASK_RESET;
      stat_q <= '0;
      susp_q <= 1'b0;
      rw_prev_q <= 1'b0;
      pe_prev_q <= 1'b0;
      st_q <= HS_PD;
      cnt_q <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata[1:0];
      end
      if (reg_wr && sel_imask) begin
        mask_q <= reg_wdata[IRQ_W-1:0];
      end
      stat_q <= stat_d;
      if (cmd_susp) begin
        susp_q <= 1'b1;
      end else if (cmd_res || ev[IRQ_REMOTE_WAKE]) begin
        susp_q <= 1'b0;
      end
      rw_prev_q <= link.remote_wake;
      pe_prev_q <= link.power_event_output;
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
      irq <= 1'b0;
      link.suspend_req <= 1'b0;
      link.resume_req <= 1'b0;
      link.set_feature <= 1'b0;
      link.phy_full_power_down <= 1'b0;
      link.phy_reset_release_n <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
      irq <= |(stat_d & mask_q);
      link.suspend_req <= cmd_susp;
      link.resume_req <= cmd_res;
      link.set_feature <= wr_ctrl ? reg_wdata[CTRL_SET_FEATURE]
        : ctrl_q[CTRL_SET_FEATURE];
      link.phy_full_power_down <= (st_d == HS_PD);
      link.phy_reset_release_n <= (st_d == HS_RDY);
    end
  end
endmodule

// file: rwps_if.sv
// link between the bridge device and its usb host controller
`timescale 1ns/1ns
interface rwps_if;
  logic suspend_req;
  logic resume_req;
  logic set_feature;
  logic phy_full_power_down;
  logic phy_reset_release_n;
  logic power_event_output;
  logic remote_wake;
  modport dev (
    input suspend_req,
    input resume_req,
    input set_feature,
    input phy_full_power_down,
    input phy_reset_release_n,
    output power_event_output,
    output remote_wake
  );
  modport host (
    output suspend_req,
    output resume_req,
    output set_feature,
    output phy_full_power_down,
    output phy_reset_release_n,
    input power_event_output,
    input remote_wake
  );
endinterface

// file: rwps_pkg.sv
// shared constants and state types for the wake and phy power sequencer
package rwps_pkg;
  // clock and timing
  localparam int CLK_MHZ = 250;
  localparam int T1_NS = 500;
  localparam int T2_MS = 600;
  localparam int T3_NS = 500;
  localparam int T1_CYC = (T1_NS * CLK_MHZ + 999) / 1000;
  localparam int T2_CYC = T2_MS * CLK_MHZ * 1000;
  localparam int T3_CYC = (T3_NS * CLK_MHZ + 999) / 1000;
  localparam int RWAKE_CYC = 16;
  localparam int BOOT_CYC = 3;
  // phy basic control register power-down bit
  localparam int PHY_CTRL_PD_BIT = 11;
  // host register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hc;
  // ctrl fields
  localparam int CTRL_SET_FEATURE = 0;
  localparam int CTRL_PHY_PD = 1;
  localparam int CTRL_SUSPEND = 2;
  localparam int CTRL_RESUME = 3;
  localparam int CTRL_SW_RESET = 4;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // irq fields
  localparam int IRQ_REMOTE_WAKE = 0;
  localparam int IRQ_POWER_EVENT = 1;
  localparam int IRQ_PHY_READY = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  typedef enum logic [3:0] {
    DS_NORMAL = 4'b0001,
    DS_SUSP = 4'b0010,
    DS_RWAKE = 4'b0100,
    DS_READY = 4'b1000
  } rwps_dev_st_t;
  typedef enum logic [3:0] {
    HS_PD = 4'b0001,
    HS_STAB = 4'b0010,
    HS_RST = 4'b0100,
    HS_RDY = 4'b1000
  } rwps_host_st_t;
endpackage

// file: rwps_sva.sv
// assertion checker for the device to host link
`timescale 1ns/1ns
module rwps_sva #(
  parameter int T2_CYCLES = 200,
  parameter int T3_CYCLES = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link signals
  input wire logic suspend_req,
  input wire logic resume_req,
  input wire logic set_feature,
  input wire logic phy_full_power_down,
  input wire logic phy_reset_release_n,
  input wire logic power_event_output,
  input wire logic remote_wake
);
  logic [4:0] rw_cnt_q;
  logic [31:0] lo_cnt_q;
  logic first_q;
  wire logic lo_clr = sys_rst || phy_full_power_down || phy_reset_release_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // length of remote wake, reset-low time, first release after power-up
  always_ff @(posedge clk) begin
    rw_cnt_q <= (sys_rst || !remote_wake) ? 5'h0 : rw_cnt_q + 5'h1;
    lo_cnt_q <= lo_clr ? 32'h0 : lo_cnt_q + 32'h1;
    first_q <= sys_rst || phy_full_power_down || (first_q && !phy_reset_release_n);
  end
  property p_rwake_len;
    $fell(remote_wake) |-> rw_cnt_q == 5'h10;
  endproperty
  property p_rwake_max;
    rw_cnt_q <= 5'h10;
  endproperty
  property p_pe_sticky;
    power_event_output |=> power_event_output;
  endproperty
  property p_first_rel;
    $rose(phy_reset_release_n) && first_q |-> lo_cnt_q >= T2_CYCLES + T3_CYCLES;
  endproperty
  property p_sw_rst;
    $rose(phy_reset_release_n) |-> lo_cnt_q >= T3_CYCLES;
  endproperty
  property p_pd_rst;
    phy_full_power_down [*2] |-> !phy_reset_release_n;
  endproperty
  property p_susp_pulse;
    suspend_req |=> !suspend_req;
  endproperty
  property p_res_pulse;
    resume_req |=> !resume_req;
  endproperty
  property p_one_cmd;
    !(suspend_req && resume_req);
  endproperty
  a_rwake_len: assert property (p_rwake_len) else $error("remote wake length wrong");
  a_rwake_max: assert property (p_rwake_max) else $error("remote wake too long");
  a_pe_sticky: assert property (p_pe_sticky) else $error("power event dropped");
  a_first_rel: assert property (p_first_rel) else $error("early release");
  a_sw_rst: assert property (p_sw_rst) else $error("phy reset too short");
  a_pd_rst: assert property (p_pd_rst) else $error("released in power-down");
  a_susp_pulse: assert property (p_susp_pulse) else $error("suspend not a pulse");
  a_res_pulse: assert property (p_res_pulse) else $error("resume not a pulse");
  a_one_cmd: assert property (p_one_cmd) else $error("suspend with resume");
  c_rwake: cover property ($rose(remote_wake));
  c_pe: cover property ($rose(power_event_output));
  c_sw_rel: cover property ($rose(phy_reset_release_n) && !first_q);
endmodule

// file: rwps_test.sv
// self-checking bench for the wake and phy power sequencer
`timescale 1ns/1ns
module rwps_test;
  import rwps_pkg::*;
  localparam int T2S = 200;
  localparam int T3S = 4;
  localparam logic [2:0] SELS [6] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h0, 3'h1};
  localparam logic [5:0] EVS [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h02};
  localparam logic [5:0] WAKE = 6'h1f;
  localparam logic [5:0] RDY_EV [4] = '{6'h02, 6'h20, 6'h10, 6'h01};
  localparam logic [3:0] RDY_WAKE = 4'h7;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic strap = 1'b0;
  logic flag = 1'b0;
  logic pmode = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [15:0] phy_ctrl = 16'h0;
  logic [5:0] ev = 6'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, d;
  logic irq, osc_en, pll_en, bandgap_en, in_rst, susp, rmode;
  int n_mismatch = 0;
  int check_count = 0;
  int n;
  always #2 clk = ~clk;
  rwps_if rwps_if_i ();
  rwps_device rwps_device_i (.clk(clk), .sys_rst(sys_rst), .link(rwps_if_i.dev),
    .default_mode_strap(strap), .remote_wake_enable_flag(flag),
    .wake_on_frame_select(sel[0]), .wake_on_magic_select(sel[1]),
    .wake_on_link_change_select(sel[2]), .phy_mode(pmode), .phy_basic_control_reg(phy_ctrl),
    .wake_frame_rx(ev[0]), .magic_packet_rx(ev[1]), .link_change_primary(ev[2]),
    .link_change_secondary(ev[3]), .secondary_link_up(ev[5]),
    .external_wake_pin_n(!ev[4]), .osc_en(osc_en), .pll_en(pll_en),
    .bandgap_en(bandgap_en), .phy_in_reset(in_rst), .suspended(susp), .ready_mode(rmode));
  rwps_host #(.T2_CYCLES(T2S), .T3_CYCLES(T3S)) rwps_host_i (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .irq(irq), .link(rwps_if_i.host));
  rwps_sva #(.T2_CYCLES(T2S), .T3_CYCLES(T3S)) rwps_sva_i (.clk(clk), .sys_rst(sys_rst),
    .suspend_req(rwps_if_i.suspend_req), .resume_req(rwps_if_i.resume_req),
    .set_feature(rwps_if_i.set_feature), .phy_full_power_down(rwps_if_i.phy_full_power_down),
    .phy_reset_release_n(rwps_if_i.phy_reset_release_n),
    .power_event_output(rwps_if_i.power_event_output), .remote_wake(rwps_if_i.remote_wake));
  function automatic logic pick(input int s);
    case (s)
      0: return rwps_if_i.remote_wake;
      1: return susp;
      2: return rwps_if_i.power_event_output;
      3: return rwps_if_i.phy_reset_release_n;
      4: return osc_en;
      default: return rmode;
    endcase
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ends just after the edge, so outputs launched there are settled
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // bounded wait, cycles spent left in n
  task automatic wait_for(input int s, input logic v, input int bound);
    #1 n = 0;
    while (pick(s) !== v && n < bound) begin
      @(posedge clk);
      #1 n++;
    end
    if (pick(s) !== v) begin
      chk({31'h0, pick(s)}, {31'h0, v});
      print_verdict();
    end
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk);
    strap <= s;
    pmode <= s;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    ev <= m;
    repeat (m[4] ? 4 : 1) @(posedge clk);
    ev <= 6'h0;
  endtask
  initial begin
    do_reset(1'b0);
    wait_for(3, 1'b1, 400);
    chk(32'(n >= T2S + T3S), 32'h1);
    step(2);
    chk(in_rst, 32'h0);
    rd_reg(OFS_IRQ_STAT);
    chk(d, 32'h4);
    chk(irq, 32'h0);
    wr_reg(OFS_IRQ_MASK, 32'h7);
    step(2);
    chk(irq, 32'h1);
    wr_reg(OFS_IRQ_STAT, 32'h4);
    step(2);
    chk(irq, 32'h0);
    rd_reg(4'h2);
    chk(d, 32'h0);
    $display("end of test 1");
    sel <= 3'h7;
    wr_reg(OFS_CTRL, 32'h4);
    step(2);
    chk(susp, 32'h1);
    pulse(6'h1f);
    step(40);
    chk(susp, 32'h1);
    rd_reg(OFS_IRQ_STAT);
    chk(d, 32'h0);
    wr_reg(OFS_CTRL, 32'h8);
    wait_for(1, 1'b0, 10);
    chk(rwps_if_i.remote_wake, 32'h0);
    $display("end of test 2");
    flag <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      sel <= SELS[k];
      wr_reg(OFS_CTRL, 32'h5);
      pulse(EVS[k]);
      step(4);
      chk(rwps_if_i.remote_wake, WAKE[k]);
      if (!WAKE[k]) wr_reg(OFS_CTRL, 32'h9);
      wait_for(0, 1'b0, 40);
      wait_for(1, 1'b0, 40);
      rd_reg(OFS_IRQ_STAT);
      chk(d[0], WAKE[k]);
      wr_reg(OFS_IRQ_STAT, 32'h1);
    end
    $display("end of test 3");
    wr_reg(OFS_CTRL, 32'h2);
    wr_reg(OFS_CTRL, 32'h0);
    wait_for(4, 1'b0, 6);
    chk({pll_en, bandgap_en, in_rst}, 32'h1);
    wait_for(4, 1'b1, 400);
    chk(32'(n >= T1_CYC - 1), 32'h1);
    wait_for(3, 1'b1, 400);
    @(posedge clk);
    phy_ctrl[PHY_CTRL_PD_BIT] <= 1'b1;
    step(4);
    chk({osc_en, pll_en, bandgap_en}, 32'h6);
    @(posedge clk);
    phy_ctrl <= 16'h0;
    step(4);
    chk(bandgap_en, 32'h1);
    wr_reg(OFS_CTRL, 32'h10);
    wait_for(3, 1'b0, 6);
    wait_for(3, 1'b1, 20);
    chk(32'(n >= T3S - 1), 32'h1);
    $display("end of test 4");
    flag <= 1'b0;
    sel <= 3'h0;
    for (int k = 0; k < 4; k++) begin
      do_reset(1'b1);
      wait_for(5, 1'b1, 10);
      pulse(RDY_EV[k]);
      step(4);
      chk(pick(2), RDY_WAKE[k]);
      chk(rmode, !RDY_WAKE[k]);
      rd_reg(OFS_IRQ_STAT);
      chk(d[1], RDY_WAKE[k]);
    end
    $display("end of test 5");
    print_verdict();
  end
endmodule
